// ---- crf_defs.svh ----
// Constants of the card reply framer: command codes, field values, timing
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

// --------
// Command indices
// --------
`define CRF_CMD0 6'h00
`define CRF_CMD2 6'h02
`define CRF_CMD3 6'h03
`define CRF_CMD4 6'h04
`define CRF_CMD6 6'h06
`define CRF_CMD7 6'h07
`define CRF_CMD9 6'h09
`define CRF_CMD10 6'h0a
`define CRF_CMD12 6'h0c
`define CRF_CMD13 6'h0d
`define CRF_CMD15 6'h0f
`define CRF_CMD16 6'h10
`define CRF_CMD17 6'h11
`define CRF_CMD18 6'h12
`define CRF_CMD22 6'h16
`define CRF_CMD23 6'h17
`define CRF_CMD24 6'h18
`define CRF_CMD25 6'h19
`define CRF_CMD27 6'h1b
`define CRF_CMD28 6'h1c
`define CRF_CMD29 6'h1d
`define CRF_CMD30 6'h1e
`define CRF_CMD32 6'h20
`define CRF_CMD33 6'h21
`define CRF_CMD38 6'h26
`define CRF_CMD41 6'h29
`define CRF_CMD42 6'h2a
`define CRF_CMD51 6'h33
`define CRF_CMD55 6'h37
`define CRF_CMD56 6'h38

// --------
// Frame layout
// --------
`define CRF_FRAME_W 136
`define CRF_LONG_LEN 8'h88
`define CRF_SHORT_LEN 8'h30
`define CRF_START_DIR 2'h0
`define CRF_END_BIT 1'h1
`define CRF_RESV_IDX 6'h3f
`define CRF_RESV_CRC 7'h7f
`define CRF_CRC_POLY 7'h09
`define CRF_PAD_W 88

// --------
// Link timing, in link clock cycles
// --------
`define CRF_NCR_MIN 4'h2

`endif

// ---- crf_pkg.sv ----
// Types shared by the card reply framer modules
package crf_pkg;

    typedef enum logic [3:0] {
        st_idle, st_ready, st_ident, st_stby, st_tran,
        st_data, st_rcv, st_prg, st_dis, st_ina
    } crf_state_t;

    typedef enum logic [2:0] {
        rp_none, rp_normal, rp_busy, rp_long_cid, rp_long_csd,
        rp_ocr, rp_addr
    } crf_reply_t;

    typedef enum logic [1:0] {
        lk_idle, lk_wait, lk_shift, lk_done
    } crf_link_state_t;

endpackage : crf_pkg

// ---- crf_reply_if.sv ----
// Reply hand-off between the system-clock framer and the link serialiser
`timescale 1ns/10ps
interface crf_reply_if #(parameter int FW = 136);
    logic req_tgl;
    logic [FW-1:0] frame;
    logic [7:0] len;
    logic busy_lvl;
    logic ack_tgl;

    modport sys (output req_tgl, output frame, output len,
                 output busy_lvl, input ack_tgl);
    modport link (input req_tgl, input frame, input len,
                  input busy_lvl, output ack_tgl);
endinterface : crf_reply_if

// ---- crf_crc7.sv ----
// CRC7 over the first 40 bits of a short reply
`timescale 1ns/10ps
`include "crf_defs.svh"
module crf_crc7 (
    input wire logic [39:0] data,
    output logic [6:0] crc
);
    import crf_pkg::*;

    logic [6:0] c;
    logic fb;

    always_comb begin
        c = 7'h00;
        fb = 1'b0;
        for (int i = 39; i >= 0; i--) begin
            fb = data[i] ^ c[6];
            c = {c[5:0], 1'b0};
            if (fb) begin
                c = c ^ `CRF_CRC_POLY;
            end
        end
        crc = c;
    end
endmodule : crf_crc7

// ---- crf_link_tx.sv ----
// Link-clock serialiser for replies on the command line, busy on data 0
`timescale 1ns/10ps
`include "crf_defs.svh"
module crf_link_tx (
    input wire logic link_clock,
    input wire logic reset,
    crf_reply_if.link rp,
    output logic cmd_out,
    output logic cmd_oe_n,
    output logic dat0_out,
    output logic dat0_oe_n
);
    import crf_pkg::*;

    // --------
    // Crossings into the link domain
    // --------
    logic rst_meta, rst_sync;
    logic req_meta, req_sync, busy_meta, busy_sync;

    always_ff @(posedge link_clock) begin
        rst_meta <= reset;
        rst_sync <= rst_meta;
        req_meta <= rp.req_tgl;
        req_sync <= req_meta;
        busy_meta <= rp.busy_lvl;
        busy_sync <= busy_meta;
    end

    // --------
    // Serialiser
    // --------
    crf_link_state_t lk_reg;
    logic [`CRF_FRAME_W-1:0] shift_reg;
    logic [7:0] bits_reg;
    logic [3:0] wait_reg;
    logic seen_reg;
    logic ack_reg;

    wire new_req = req_sync != seen_reg;
    wire last_bit = bits_reg == 8'h01;

    always_ff @(posedge link_clock) begin
        if (rst_sync) begin
            lk_reg <= lk_idle;
            shift_reg <= '0;
            bits_reg <= 8'h00;
            wait_reg <= 4'h0;
            seen_reg <= 1'b0;
            ack_reg <= 1'b0;
            cmd_out <= 1'b1;
            cmd_oe_n <= 1'b1;
        end else begin
            unique case (lk_reg)
                lk_idle: begin
                    cmd_oe_n <= 1'b1;
                    if (new_req) begin
                        // Frame held stable by the sender until ack
                        shift_reg <= rp.frame;
                        bits_reg <= rp.len;
                        wait_reg <= `CRF_NCR_MIN;
                        lk_reg <= lk_wait;
                    end
                end
                lk_wait: begin
                    // Bus turnaround before the card drives
                    wait_reg <= wait_reg - 4'h1;
                    if (wait_reg == 4'h1) begin
                        lk_reg <= lk_shift;
                    end
                end
                lk_shift: begin
                    cmd_out <= shift_reg[`CRF_FRAME_W-1];
                    cmd_oe_n <= 1'b0;
                    shift_reg <= {shift_reg[`CRF_FRAME_W-2:0], 1'b0};
                    bits_reg <= bits_reg - 8'h01;
                    if (last_bit) begin
                        lk_reg <= lk_done;
                    end
                end
                lk_done: begin
                    cmd_oe_n <= 1'b1;
                    cmd_out <= 1'b1;
                    seen_reg <= req_sync;
                    ack_reg <= ~ack_reg;
                    lk_reg <= lk_idle;
                end
            endcase
        end
    end

    // Busy is driven low on data 0; released otherwise
    always_ff @(posedge link_clock) begin
        if (rst_sync) begin
            dat0_out <= 1'b1;
            dat0_oe_n <= 1'b1;
        end else begin
            dat0_out <= 1'b0;
            dat0_oe_n <= ~busy_sync;
        end
    end

    assign rp.ack_tgl = ack_reg;
endmodule : crf_link_tx

// ---- crf_card_reply_framer.sv ----
// Card reply framer: card state tail, reply framing, link hand-off
//
// Behaviour
// - Replies go out serially on the command line, MSB first, length by type.
// - Every reply opens with start bit 0 and direction bit 0.
// - All replies carry CRC7 except the operating-condition reply.
// - Every reply ends with an end bit of one.
// - Normal reply: 48 bits, index 45:40, status 39:8, CRC7 7:1.
// - Card may hold data line busy after each written block; host checks.
// - Busy reply has normal format; busy may follow; host checks at reply.
// - Long reply: 136 bits, six reserved ones, then 127 register bits.
// - CMD2 and CMD10 return identity register, CMD9 specific data register.
// - Only register bits 127 to 1 sent; end bit replaces bit 0.
// - ACMD41 reply: register in 39:8, ones in 45:40 and 7:1.
// - Fourth and fifth reply formats are never produced.
// - Address reply carries index 000011.
// - Address reply: new address high, status 23,22,19,12:0 low.
// - ACMD41 in idle: ready if supply fits, stays idle while powering up.
// - ACMD41 in idle with unfit supply: shut-out state, off the bus.
// - CMD7 selecting card: standby to transfer, deselected-writing to programming.
// - CMD7 selecting other: transfer, data, standby to standby; programming out.
`timescale 1ns/10ps
`include "crf_defs.svh"
module crf_card_reply_framer (
    input wire logic clock,
    input wire logic reset,
    input wire logic link_clock,
    input wire logic cmd_valid,
    input wire logic [5:0] cmd_index,
    input wire logic cmd_app,
    input wire logic cmd_write,
    input wire logic card_addressed,
    input wire logic vdd_compatible,
    input wire logic powerup_busy,
    input wire logic data_done,
    input wire logic prog_done,
    input wire logic write_buf_busy,
    input wire logic [31:0] card_status,
    input wire logic [31:0] op_cond,
    input wire logic [127:0] card_identity,
    input wire logic [127:0] card_specific_data,
    input wire logic [15:0] relative_card_address,
    output crf_pkg::crf_state_t card_state,
    output logic reply_pending,
    output logic reply_done,
    output logic cmd_illegal,
    output logic cmd_out,
    output logic cmd_oe_n,
    output logic dat0_out,
    output logic dat0_oe_n
);
    import crf_pkg::*;

    // --------
    // Registers
    // --------
    crf_state_t state_reg, state_next;
    crf_reply_t kind_next;
    logic legal_next;
    logic [`CRF_FRAME_W-1:0] frame_reg;
    logic [7:0] len_reg;
    logic req_tgl_reg;
    logic pend_reg;
    logic done_reg;
    logic illegal_reg;
    logic busy_reg;
    logic ack_meta, ack_sync, ack_last;

    crf_reply_if #(.FW(`CRF_FRAME_W)) rp ();

    // --------
    // Command-driven state changes
    // --------
    // A command arriving while a reply is still on the link is refused:
    // the frame buffer is single and must stay stable for the crossing.
    wire take = cmd_valid && !pend_reg;
    wire in_stby_to_dis = state_reg inside {st_stby, st_tran, st_data,
                                            st_rcv, st_prg, st_dis};

    always_comb begin
        state_next = state_reg;
        kind_next = rp_none;
        legal_next = 1'b0;
        if (state_reg == st_ina) begin
            // Shut out: nothing is answered, not even go-idle
            legal_next = 1'b0;
        end else if (cmd_app) begin
            unique case (cmd_index)
                `CRF_CMD41: begin
                    if (state_reg == st_idle) begin
                        legal_next = 1'b1;
                        if (!vdd_compatible) begin
                            state_next = st_ina;
                        end else if (powerup_busy) begin
                            state_next = st_idle;
                            kind_next = rp_ocr;
                        end else begin
                            state_next = st_ready;
                            kind_next = rp_ocr;
                        end
                    end
                end
                `CRF_CMD6, `CRF_CMD13, `CRF_CMD22, `CRF_CMD23,
                `CRF_CMD42: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        kind_next = rp_normal;
                    end
                end
                `CRF_CMD51: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        state_next = st_data;
                        kind_next = rp_normal;
                    end
                end
                default: begin
                    legal_next = 1'b0;
                end
            endcase
        end else begin
            unique case (cmd_index)
                `CRF_CMD0: begin
                    legal_next = 1'b1;
                    state_next = st_idle;
                end
                `CRF_CMD2: begin
                    if (state_reg == st_ready) begin
                        legal_next = 1'b1;
                        state_next = st_ident;
                        kind_next = rp_long_cid;
                    end
                end
                `CRF_CMD3: begin
                    if (state_reg inside {st_ident, st_stby}) begin
                        legal_next = 1'b1;
                        state_next = st_stby;
                        kind_next = rp_addr;
                    end
                end
                `CRF_CMD4: begin
                    legal_next = state_reg == st_stby;
                end
                `CRF_CMD7: begin
                    if (card_addressed) begin
                        if (state_reg == st_stby) begin
                            legal_next = 1'b1;
                            state_next = st_tran;
                            kind_next = rp_busy;
                        end else if (state_reg == st_dis) begin
                            legal_next = 1'b1;
                            state_next = st_prg;
                            kind_next = rp_busy;
                        end
                    end else begin
                        // Deselected cards stay silent on the bus
                        if (state_reg inside {st_stby, st_tran, st_data}) begin
                            legal_next = 1'b1;
                            state_next = st_stby;
                        end else if (state_reg == st_prg) begin
                            legal_next = 1'b1;
                            state_next = st_dis;
                        end
                    end
                end
                `CRF_CMD9: begin
                    if (state_reg == st_stby) begin
                        legal_next = 1'b1;
                        kind_next = rp_long_csd;
                    end
                end
                `CRF_CMD10: begin
                    if (state_reg == st_stby) begin
                        legal_next = 1'b1;
                        kind_next = rp_long_cid;
                    end
                end
                `CRF_CMD12: begin
                    if (state_reg == st_data) begin
                        legal_next = 1'b1;
                        state_next = st_tran;
                        kind_next = rp_busy;
                    end else if (state_reg == st_rcv) begin
                        legal_next = 1'b1;
                        state_next = st_prg;
                        kind_next = rp_busy;
                    end
                end
                `CRF_CMD13: begin
                    if (in_stby_to_dis) begin
                        legal_next = 1'b1;
                        kind_next = rp_normal;
                    end
                end
                `CRF_CMD15: begin
                    if (in_stby_to_dis) begin
                        legal_next = 1'b1;
                        state_next = st_ina;
                    end
                end
                `CRF_CMD16, `CRF_CMD32, `CRF_CMD33: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        kind_next = rp_normal;
                    end
                end
                `CRF_CMD17, `CRF_CMD18, `CRF_CMD30: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        state_next = st_data;
                        kind_next = rp_normal;
                    end
                end
                `CRF_CMD24, `CRF_CMD25, `CRF_CMD27: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        state_next = st_rcv;
                        kind_next = rp_normal;
                    end
                end
                `CRF_CMD28, `CRF_CMD29, `CRF_CMD38: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        state_next = st_prg;
                        kind_next = rp_busy;
                    end
                end
                `CRF_CMD55: begin
                    if (state_reg == st_idle || in_stby_to_dis) begin
                        legal_next = 1'b1;
                        kind_next = rp_normal;
                    end
                end
                `CRF_CMD56: begin
                    if (state_reg == st_tran) begin
                        legal_next = 1'b1;
                        kind_next = rp_normal;
                        state_next = cmd_write ? st_rcv : st_data;
                    end
                end
                default: begin
                    legal_next = 1'b0;
                end
            endcase
        end
    end

    // --------
    // Reply framing
    // --------
    wire is_ocr = kind_next == rp_ocr;
    wire is_addr = kind_next == rp_addr;
    wire is_long = kind_next inside {rp_long_cid, rp_long_csd};
    wire has_reply = kind_next != rp_none;

    wire [15:0] addr_status = {card_status[23], card_status[22],
                               card_status[19], card_status[12:0]};
    wire [5:0] idx_field = is_ocr ? `CRF_RESV_IDX : cmd_index;
    wire [31:0] payload = is_ocr ? op_cond
                        : is_addr ? {relative_card_address,
                                     addr_status}
                        : card_status;
    wire [39:0] crc_in = {`CRF_START_DIR, idx_field, payload};
    wire [6:0] crc_calc;
    wire [6:0] crc_field = is_ocr ? `CRF_RESV_CRC : crc_calc;
    wire [47:0] short_frame = {crc_in, crc_field,
                               `CRF_END_BIT};
    wire [127:0] long_reg = kind_next == rp_long_csd ? card_specific_data
                                                     : card_identity;
    wire [`CRF_FRAME_W-1:0] long_frame = {`CRF_START_DIR, `CRF_RESV_IDX,
                                          long_reg[127:1],
                                          `CRF_END_BIT};
    wire [`CRF_FRAME_W-1:0] frame_sel = is_long ? long_frame
                         : {short_frame, {`CRF_PAD_W{1'b0}}};
    wire [7:0] len_sel = is_long ? `CRF_LONG_LEN
                                 : `CRF_SHORT_LEN;

    crf_crc7 u_crc (
        .data(crc_in),
        .crc(crc_calc)
    );

    // --------
    // Acknowledge crossing back from the link domain
    // --------
    wire ack_evt = ack_sync != ack_last;

    always_ff @(posedge clock) begin
        if (reset) begin
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
            ack_last <= 1'b0;
        end else begin
            ack_meta <= rp.ack_tgl;
            ack_sync <= ack_meta;
            ack_last <= ack_sync;
        end
    end

    // --------
    // State and hand-off
    // --------
    wire cmd_ok = take && legal_next;
    wire send = cmd_ok && has_reply;

    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= st_idle;
        end else if (cmd_ok) begin
            state_reg <= state_next;
        end else if (prog_done && state_reg == st_prg) begin
            state_reg <= st_tran;
        end else if (prog_done && state_reg == st_dis) begin
            state_reg <= st_stby;
        end else if (data_done && state_reg == st_data) begin
            state_reg <= st_tran;
        end else if (data_done && state_reg == st_rcv) begin
            state_reg <= st_prg;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            frame_reg <= '0;
            len_reg <= 8'h00;
            req_tgl_reg <= 1'b0;
        end else if (send) begin
            frame_reg <= frame_sel;
            len_reg <= len_sel;
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            pend_reg <= 1'b0;
            done_reg <= 1'b0;
            illegal_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            // Set and clear cannot meet: a send needs pend low
            pend_reg <= send | (pend_reg & ~ack_evt);
            done_reg <= ack_evt;
            illegal_reg <= cmd_valid && !cmd_ok;
            // Busy in programming or on write_buf_busy; CMD7 and CMD12 busy replies that lead to transfer add none
            busy_reg <= state_reg == st_prg || write_buf_busy;
        end
    end

    assign rp.req_tgl = req_tgl_reg;
    assign rp.frame = frame_reg;
    assign rp.len = len_reg;
    assign rp.busy_lvl = busy_reg;

    crf_link_tx u_link (
        .link_clock(link_clock),
        .reset(reset),
        .rp(rp),
        .cmd_out(cmd_out),
        .cmd_oe_n(cmd_oe_n),
        .dat0_out(dat0_out),
        .dat0_oe_n(dat0_oe_n)
    );

    assign card_state = state_reg;
    assign reply_pending = pend_reg;
    assign reply_done = done_reg;
    assign cmd_illegal = illegal_reg;
endmodule : crf_card_reply_framer

// ---- crf_card_reply_framer_properties.sv ----
// Port checker for the card reply framer, bound to its top module
`timescale 1ns/10ps
`include "crf_defs.svh"
module crf_card_reply_framer_properties (
    input wire logic clock,
    input wire logic reset,
    input wire logic link_clock,
    input wire logic cmd_valid,
    input wire logic [5:0] cmd_index,
    input wire logic cmd_app,
    input wire logic card_addressed,
    input wire logic vdd_compatible,
    input wire logic powerup_busy,
    input wire logic write_buf_busy,
    input wire crf_pkg::crf_state_t card_state,
    input wire logic reply_pending,
    input wire logic cmd_out,
    input wire logic cmd_oe_n,
    input wire logic dat0_oe_n
);
    import crf_pkg::*;
    wire logic take = cmd_valid && !reply_pending && !cmd_app;
    wire logic a41 = cmd_valid && !reply_pending && cmd_app
        && cmd_index == `CRF_CMD41 && card_state == st_idle;
    wire logic sel7 = take && cmd_index == `CRF_CMD7;
    ocr_ready_a: assert property (@(posedge clock) disable iff (reset)
        a41 && vdd_compatible && !powerup_busy |=> card_state == st_ready)
        else $error("no move to ready");
    shut_out_a: assert property (@(posedge clock) disable iff (reset)
        a41 && !vdd_compatible |=> card_state == st_ina && !reply_pending)
        else $error("no shut-out");
    card_select_a: assert property (@(posedge clock)
        disable iff (reset) sel7 && card_addressed && card_state == st_stby
        |=> card_state == st_tran) else $error("select missed");
    card_drop_a: assert property (@(posedge clock) disable iff (reset)
        sel7 && !card_addressed && card_state == st_prg
        |=> card_state == st_dis) else $error("deselect missed");
    app_keep_a: assert property (@(posedge clock) disable iff (reset)
        take && cmd_index == `CRF_CMD55 && card_state == st_tran
        |=> $stable(card_state)) else $error("state moved on prefix");
    start_dir_a: assert property (@(posedge link_clock)
        disable iff (reset) $fell(cmd_oe_n) |-> !cmd_out ##1 !cmd_out)
        else $error("bad start or direction bit");
    end_bit_a: assert property (@(posedge link_clock)
        disable iff (reset) $rose(cmd_oe_n) |-> $past(cmd_out))
        else $error("bad end bit");
    busy_line_a: assert property (@(posedge clock) disable iff (reset)
        write_buf_busy [*4] |-> !dat0_oe_n) else $error("no busy");
    cover property (@(posedge clock) a41);
    cover property (@(posedge clock) card_state == st_dis);
    cover property (@(posedge link_clock) $rose(cmd_oe_n));
endmodule : crf_card_reply_framer_properties

bind crf_card_reply_framer crf_card_reply_framer_properties
    crf_card_reply_framer_properties_i (.*);

// ---- crf_host_model.sv ----
// Host side: gated bus clock and capture of replies on the command line
`timescale 1ns/10ps
module crf_host_model (
    input wire logic run,
    input wire logic clr,
    input wire logic cmd_out,
    input wire logic cmd_oe_n,
    output logic link_clock,
    output logic [135:0] frame,
    output logic [7:0] nbits
);
    // Released line floats high on its pull-up
    wire logic cmd_line = cmd_oe_n ? 1'h1 : cmd_out;
    initial begin
        link_clock = 1'h0;
        #1.3;
        forever #3 link_clock = run ? ~link_clock : 1'h0;
    end
    always @(posedge link_clock or posedge clr) begin
        if (clr) begin
            {frame, nbits} <= '0;
        end else if (!cmd_oe_n) begin
            {frame, nbits} <= {frame[134:0], cmd_line, nbits + 8'h01};
        end
    end
endmodule : crf_host_model

// ---- crf_card_reply_framer_test.sv ----
// Self-checking bench of the card reply framer
`timescale 1ns/10ps
`include "crf_defs.svh"
module crf_card_reply_framer_test;
    import crf_pkg::*;
    logic clock, reset, link_clock, cmd_valid, cmd_app, cmd_write, clr;
    logic card_addressed, vdd_compatible, powerup_busy, data_done;
    logic prog_done, write_buf_busy, reply_pending, reply_done, run;
    logic cmd_illegal, cmd_out, cmd_oe_n, dat0_out, dat0_oe_n;
    logic [5:0] cmd_index;
    logic [7:0] nbits;
    logic [15:0] relative_card_address;
    logic [31:0] card_status, op_cond;
    logic [127:0] card_identity, card_specific_data;
    logic [135:0] frame;
    crf_state_t card_state;
    int err_total = 0;
    int cmp_count = 0;
    logic [6:0] keep [8] = '{7'h20, 7'h21, 7'h46, 7'h4d, 7'h56, 7'h57,
        7'h6a, 7'h37};
    // Bus clock stands still unless in reset or the card has something to put out
    assign run = reset | reply_pending | write_buf_busy | ~dat0_oe_n
        | (card_state == st_prg);
    crf_card_reply_framer crf_card_reply_framer_i (.*);
    crf_host_model crf_host_model_i (.*);
    function automatic logic [135:0] sf(logic [5:0] i, logic [31:0] p);
        logic [39:0] h;
        logic [6:0] c;
        h = {2'h0, i, p};
        c = 7'h00;
        for (int k = 39; k >= 0; k--)
            c = {c[5:0], 1'h0} ^ ((h[k] ^ c[6]) ? `CRF_CRC_POLY : 7'h00);
        return {88'h0, h, c, 1'h1};
    endfunction : sf
    task automatic check(string n, logic [135:0] s, logic [135:0] e);
        cmp_count++;
        if (s !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask : check
    task automatic cmd(logic [5:0] i, logic a, crf_state_t s);
        crf_state_t p = card_state;
        @(posedge clock);
        {cmd_valid, clr, cmd_app, cmd_index} <= {2'h3, a, i};
        @(posedge clock);
        {cmd_valid, clr} <= 2'h0;
        #1 check("illegal", 136'(cmd_illegal), 136'(p == st_ina));
        #50;
        for (int n = 0; n < 60 && reply_pending !== 1'h0; n++)
            #25;
        check("state", 136'(card_state), 136'(s));
        check("pending", 136'(reply_pending), 136'h0);
    endtask : cmd
    task automatic fr(logic [135:0] e, logic [7:0] n);
        check("frame", frame, e);
        check("length", 136'(nbits), 136'(n));
        check("done", 136'(reply_done), 136'(n != 8'h00));
    endtask : fr
    task automatic done(logic p);
        @(posedge clock);
        {data_done, prog_done} <= {~p, p};
        @(posedge clock);
        {data_done, prog_done} <= 2'h0;
    endtask : done
    task automatic results;
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : results
    initial begin
        clock = 1'h0;
        forever #12.5 clock = ~clock;
    end
    initial begin
        #100us;
        err_total++;
        results();
    end
    initial begin
        {reset, clr, cmd_valid, cmd_app, cmd_write, card_addressed} = 6'h20;
        {data_done, prog_done, write_buf_busy, cmd_index} = 9'h0;
        {vdd_compatible, powerup_busy} = 2'h3;
        void'($urandom(95));
        {card_status, op_cond, relative_card_address} = {$urandom, $urandom,
            16'($urandom)};
        card_identity = {$urandom, $urandom, $urandom, $urandom};
        card_specific_data = {$urandom, $urandom, $urandom, $urandom};
        repeat (4) @(posedge clock);
        reset <= 1'h0;
        cmd(`CRF_CMD41, 1'h1, st_idle);
        fr({90'h0, 6'h3f, op_cond, 7'h7f, 1'h1}, 8'h30);
        powerup_busy <= 1'h0;
        cmd(`CRF_CMD41, 1'h1, st_ready);
        cmd(`CRF_CMD2, 1'h0, st_ident);
        fr({2'h0, 6'h3f, card_identity[127:1], 1'h1}, 8'h88);
        cmd(`CRF_CMD3, 1'h0, st_stby);
        fr(sf(`CRF_CMD3, {relative_card_address, card_status[23:22],
            card_status[19], card_status[12:0]}), 8'h30);
        cmd(`CRF_CMD9, 1'h0, st_stby);
        fr({2'h0, 6'h3f, card_specific_data[127:1], 1'h1}, 8'h88);
        {card_status, card_addressed} <= {$urandom, 1'h1};
        cmd(`CRF_CMD7, 1'h0, st_tran);
        fr(sf(`CRF_CMD7, card_status), 8'h30);
        $display("identification test done");
        foreach (keep[k]) cmd(keep[k][5:0], keep[k][6], st_tran);
        write_buf_busy <= 1'h1;
        repeat (6) @(posedge clock);
        #1 check("busy", 136'(dat0_oe_n), 136'h0);
        check("busy level", 136'(dat0_out), 136'h0);
        {write_buf_busy, cmd_write} <= 2'h1;
        cmd(`CRF_CMD56, 1'h0, st_rcv);
        done(1'h0);
        cmd(`CRF_CMD13, 1'h0, st_prg);
        done(1'h1);
        cmd(`CRF_CMD38, 1'h0, st_prg);
        check("busy", 136'(dat0_oe_n), 136'h0);
        card_addressed <= 1'h0;
        cmd(`CRF_CMD7, 1'h0, st_dis);
        card_addressed <= 1'h1;
        cmd(`CRF_CMD7, 1'h0, st_prg);
        done(1'h1);
        cmd(`CRF_CMD51, 1'h1, st_data);
        card_addressed <= 1'h0;
        cmd(`CRF_CMD7, 1'h0, st_stby);
        $display("transfer test done");
        {vdd_compatible, powerup_busy} <= 2'h0;
        cmd(`CRF_CMD0, 1'h0, st_idle);
        cmd(`CRF_CMD41, 1'h1, st_ina);
        fr(136'h0, 8'h00);
        cmd(`CRF_CMD0, 1'h0, st_ina);
        $display("shut-out test done");
        results();
    end
endmodule : crf_card_reply_framer_test
